// ### src/canmon_top.sv
`timescale 1ns/1ps
`include "canmon_regs.svh"
module canmon_top #(
  parameter int CLK_MHZ = `CANMON_CLK_MHZ,
  parameter int EVAL_CYCLES = `CANMON_EVAL_MS * 1000 * CLK_MHZ,
  parameter int IDLE_SHORT_WIN =
    `CANMON_IDLE_SHORT_MIN * 60 * 1000 / `CANMON_EVAL_MS,
  parameter int IDLE_LONG_WIN =
    `CANMON_IDLE_LONG_MIN * 60 * 1000 / `CANMON_EVAL_MS,
  parameter int CNT_W = 16,
  parameter int SP_W = 16,
  parameter int TOL_SHIFT = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Monitored line
  input wire logic can_rx,
  // Power control handshake
  input wire logic pwr_low,
  output logic lp_req,
  output logic wake_req,
  // Indicator and search
  output logic lamp_flash,
  output logic send_allowed,
  output logic can_active
);
  import canmon_pkg::*;

  localparam int BIT250_CYC = `CANMON_BIT250_NS * CLK_MHZ / 1000;
  localparam int BIT500_CYC = `CANMON_BIT500_NS * CLK_MHZ / 1000;
  localparam int MIN_PULSE_CYC =
    (`CANMON_MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int EV_W = $clog2(EVAL_CYCLES + 1);
  localparam int ID_W = $clog2(IDLE_LONG_WIN + 2);

  logic [7:0] power_control_byte;
  logic [7:0] activity_option_byte;
  logic [7:0] rate_match_option_byte;
  logic [4:0] search_reg;
  logic [15:0] ns_bit_reg;
  logic [EV_W-1:0] ev_cnt_reg;
  logic win_tick;
  logic [CNT_W-1:0] win_count;
  logic [SP_W-1:0] win_spacing;
  logic win_active;
  logic active_prev_reg;
  logic active_before_lp_reg;
  logic [ID_W-1:0] idle_reg;
  logic idle_done;
  canmon_state_t state_reg;
  canmon_state_t state_next;
  canmon_freq_t freq_reg;
  canmon_rate_t rate_sel;
  logic lp_path_ok;
  logic wake_ok;
  logic acc_wr;
  logic acc_rd;
  logic mapped;

  // ============================================================
  // Band check: spacing within tolerance of two bit times
  function automatic logic in_band(input logic [SP_W-1:0] meas,
                                   input logic [15:0] bit_cyc);
    logic [17:0] nom;
    logic [17:0] tol;
    logic [17:0] m;
    nom = {1'b0, bit_cyc, 1'b0};
    tol = nom >> TOL_SHIFT;
    m = 18'(meas);
    in_band = (m + tol >= nom) && (m <= nom + tol);
  endfunction

  // ============================================================
  // Address decode
  function automatic logic is_mapped(input logic [11:0] a);
    if (a == `CANMON_PWR_CTRL_OFS) begin
      is_mapped = 1'b1;
    end else if (a == `CANMON_ACT_OPT_OFS) begin
      is_mapped = 1'b1;
    end else if (a == `CANMON_RATE_OPT_OFS) begin
      is_mapped = 1'b1;
    end else if (a == `CANMON_SEARCH_OFS) begin
      is_mapped = 1'b1;
    end else if (a == `CANMON_NS_BIT_OFS) begin
      is_mapped = 1'b1;
    end else if (a == `CANMON_STATUS_OFS) begin
      is_mapped = 1'b1;
    end else if (a == `CANMON_SPACING_OFS) begin
      is_mapped = 1'b1;
    end else begin
      is_mapped = 1'b0;
    end
  endfunction

  assign mapped = is_mapped(paddr);
  assign acc_wr = psel & penable & pwrite & mapped;
  assign acc_rd = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ============================================================
  // Register writes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      power_control_byte <= `CANMON_PWR_CTRL_RST;
      activity_option_byte <= `CANMON_ACT_OPT_RST;
      rate_match_option_byte <= `CANMON_RATE_OPT_RST;
      search_reg <= `CANMON_SEARCH_RST;
      ns_bit_reg <= `CANMON_NS_BIT_RST;
    end else if (acc_wr) begin
      if (paddr == `CANMON_PWR_CTRL_OFS) begin
        power_control_byte <= pwdata[7:0];
      end else if (paddr == `CANMON_ACT_OPT_OFS) begin
        activity_option_byte <= pwdata[7:0];
      end else if (paddr == `CANMON_RATE_OPT_OFS) begin
        rate_match_option_byte <= pwdata[7:0];
      end else if (paddr == `CANMON_SEARCH_OFS) begin
        search_reg <= pwdata[4:0];
      end else if (paddr == `CANMON_NS_BIT_OFS) begin
        ns_bit_reg <= pwdata[15:0];
      end
    end
  end

  // ============================================================
  // Read data, captured in setup phase
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= '0;
    end else if (acc_rd) begin
      if (paddr == `CANMON_PWR_CTRL_OFS) begin
        prdata <= {24'h00_0000, power_control_byte};
      end else if (paddr == `CANMON_ACT_OPT_OFS) begin
        prdata <= {24'h00_0000, activity_option_byte};
      end else if (paddr == `CANMON_RATE_OPT_OFS) begin
        prdata <= {24'h00_0000, rate_match_option_byte};
      end else if (paddr == `CANMON_SEARCH_OFS) begin
        prdata <= {27'h000_0000, search_reg};
      end else if (paddr == `CANMON_NS_BIT_OFS) begin
        prdata <= {16'h0000, ns_bit_reg};
      end else if (paddr == `CANMON_STATUS_OFS) begin
        prdata <= {16'h0000, win_count[7:0], 2'b00, freq_reg,
                   state_reg, send_allowed, can_active};
      end else if (paddr == `CANMON_SPACING_OFS) begin
        prdata <= {{(32-SP_W){1'b0}}, win_spacing};
      end else begin
        prdata <= '0;
      end
    end
  end

  // ============================================================
  // Evaluation interval divider
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ev_cnt_reg <= '0;
    end else if (ev_cnt_reg == EV_W'(EVAL_CYCLES - 1)) begin
      ev_cnt_reg <= '0;
    end else begin
      ev_cnt_reg <= ev_cnt_reg + EV_W'(1);
    end
  end
  assign win_tick = (ev_cnt_reg == EV_W'(EVAL_CYCLES - 1));

  canmon_edge_counter #(
    .CNT_W(CNT_W),
    .SP_W(SP_W)
  ) u_counter (
    .clk_sys(clk_sys),
    .rst(rst),
    .can_rx(can_rx),
    .win_tick(win_tick),
    .win_count(win_count),
    .win_spacing(win_spacing)
  );

  // ============================================================
  // Activity decision per interval
  always_comb begin
    if (activity_option_byte[`CANMON_ACT_EDGE_BIT]) begin
      win_active = (win_count != '0);
    end else begin
      win_active = (win_count >= CNT_W'(`CANMON_ACT_THRESH));
    end
  end

  // Decision registered one cycle after the window closes
  logic judge_reg;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      judge_reg <= 1'b0;
    end else begin
      judge_reg <= win_tick;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      can_active <= 1'b0;
      active_prev_reg <= 1'b0;
    end else if (judge_reg) begin
      can_active <= win_active;
      active_prev_reg <= can_active;
    end
  end

  // ============================================================
  // Inactivity timer in intervals
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      idle_reg <= '0;
    end else if (judge_reg) begin
      if (win_active) begin
        idle_reg <= '0;
      end else if (!idle_done) begin
        idle_reg <= idle_reg + ID_W'(1);
      end
    end
  end

  always_comb begin
    if (activity_option_byte[`CANMON_ACT_LONG_BIT]) begin
      idle_done = idle_reg > ID_W'(IDLE_LONG_WIN);
    end else begin
      idle_done = idle_reg > ID_W'(IDLE_SHORT_WIN);
    end
  end

  assign lp_path_ok = power_control_byte[`CANMON_PWR_MASTER_BIT]
    & activity_option_byte[`CANMON_ACT_LP_EN_BIT]
    & ~search_reg[`CANMON_SRCH_MON_BIT];

  assign wake_ok = activity_option_byte[`CANMON_ACT_WAKE_BIT]
    | active_before_lp_reg;

  // ============================================================
  // Power state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CANMON_RUN: begin
        if (pwr_low) begin
          state_next = CANMON_SLEEP;
        end else if (idle_done && lp_path_ok) begin
          state_next = CANMON_REQ;
        end
      end
      CANMON_REQ: begin
        if (pwr_low) begin
          state_next = CANMON_SLEEP;
        end else if (!idle_done || !lp_path_ok) begin
          state_next = CANMON_RUN;
        end
      end
      CANMON_SLEEP: begin
        if (!pwr_low) begin
          state_next = CANMON_RUN;
        end else if (judge_reg && win_active && !can_active
                     && wake_ok) begin
          state_next = CANMON_WAKE;
        end
      end
      CANMON_WAKE: begin
        if (!pwr_low) begin
          state_next = CANMON_RUN;
        end
      end
      default: begin
        state_next = CANMON_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= CANMON_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Activity history captured on low power entry
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      active_before_lp_reg <= 1'b0;
    end else if (state_reg != CANMON_SLEEP && state_next == CANMON_SLEEP)
    begin
      active_before_lp_reg <= can_active | active_prev_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lp_req <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      lp_req <= (state_next == CANMON_REQ);
      wake_req <= (state_next == CANMON_WAKE);
    end
  end

  // ============================================================
  // Indicator flashing in low power
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lamp_flash <= 1'b0;
    end else if (state_reg != CANMON_SLEEP
                 || !activity_option_byte[`CANMON_ACT_LAMP_BIT]) begin
      lamp_flash <= 1'b0;
    end else if (win_tick) begin
      lamp_flash <= ~lamp_flash;
    end
  end

  // ============================================================
  // Frequency classification
  assign rate_sel = canmon_rate_t'(search_reg[3:2]);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      freq_reg <= CANMON_FREQ_NONE;
    end else if (judge_reg) begin
      if (win_spacing == '1 || win_spacing < SP_W'(MIN_PULSE_CYC)) begin
        freq_reg <= CANMON_FREQ_NONE;
      end else if (in_band(win_spacing, 16'(BIT250_CYC))) begin
        freq_reg <= CANMON_FREQ_250;
      end else if (in_band(win_spacing, 16'(BIT500_CYC))) begin
        freq_reg <= CANMON_FREQ_500;
      end else begin
        freq_reg <= CANMON_FREQ_OTHER;
      end
    end
  end

  // ============================================================
  // Send permission during protocol search
  logic match;
  logic std_seen;
  logic ns_match;
  assign ns_match = in_band(win_spacing, ns_bit_reg);
  assign std_seen = (freq_reg == CANMON_FREQ_250)
    || (freq_reg == CANMON_FREQ_500);

  always_comb begin
    case (rate_sel)
      CANMON_RATE_250: match = (freq_reg == CANMON_FREQ_250);
      CANMON_RATE_500: match = (freq_reg == CANMON_FREQ_500);
      CANMON_RATE_NS: match = !std_seen && ns_match;
      default: match = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      send_allowed <= 1'b1;
    end else if (!search_reg[`CANMON_SRCH_ON_BIT]) begin
      send_allowed <= 1'b1;
    end else if (search_reg[`CANMON_SRCH_BYP_BIT]) begin
      send_allowed <= 1'b1;
    end else if (freq_reg == CANMON_FREQ_NONE) begin
      send_allowed <= rate_match_option_byte[`CANMON_RATE_NOSIG_BIT];
    end else if (rate_sel == CANMON_RATE_NS && std_seen
                 && rate_match_option_byte[`CANMON_RATE_BLOCK_BIT]) begin
      send_allowed <= 1'b0;
    end else if (!rate_match_option_byte[`CANMON_RATE_MATCH_BIT]) begin
      send_allowed <= 1'b1;
    end else begin
      send_allowed <= match;
    end
  end
endmodule

// ### src/canmon_regs.svh
`ifndef CANMON_REGS_SVH
`define CANMON_REGS_SVH
// ============================================================
// Register offsets
`define CANMON_PWR_CTRL_OFS 12'h000
`define CANMON_ACT_OPT_OFS 12'h004
`define CANMON_RATE_OPT_OFS 12'h008
`define CANMON_SEARCH_OFS 12'h00C
`define CANMON_NS_BIT_OFS 12'h010
`define CANMON_STATUS_OFS 12'h014
`define CANMON_SPACING_OFS 12'h018
// ============================================================
// Reset values
`define CANMON_PWR_CTRL_RST 8'h80
`define CANMON_ACT_OPT_RST 8'h08
`define CANMON_RATE_OPT_RST 8'hFF
`define CANMON_SEARCH_RST 5'h00
`define CANMON_NS_BIT_RST 16'h03E8
// ============================================================
// Field positions
`define CANMON_PWR_MASTER_BIT 7
`define CANMON_ACT_LONG_BIT 1
`define CANMON_ACT_EDGE_BIT 2
`define CANMON_ACT_WAKE_BIT 3
`define CANMON_ACT_LAMP_BIT 4
`define CANMON_ACT_LP_EN_BIT 7
`define CANMON_RATE_MATCH_BIT 0
`define CANMON_RATE_BLOCK_BIT 1
`define CANMON_RATE_NOSIG_BIT 2
`define CANMON_SRCH_ON_BIT 0
`define CANMON_SRCH_BYP_BIT 1
`define CANMON_SRCH_RATE_LSB 2
`define CANMON_SRCH_MON_BIT 4
// ============================================================
// Timing
`define CANMON_CLK_MHZ 200
`define CANMON_MIN_PULSE_NS 30
`define CANMON_EVAL_MS 20
`define CANMON_IDLE_SHORT_MIN 2
`define CANMON_IDLE_LONG_MIN 10
`define CANMON_ACT_THRESH 8
`define CANMON_BIT250_NS 4000
`define CANMON_BIT500_NS 2000
`endif

// ### src/canmon_pkg.sv
package canmon_pkg;
  typedef enum logic [1:0] {
    CANMON_RUN = 2'b00,
    CANMON_REQ = 2'b01,
    CANMON_SLEEP = 2'b11,
    CANMON_WAKE = 2'b10
  } canmon_state_t;
  typedef enum logic [1:0] {
    CANMON_RATE_250 = 2'b00,
    CANMON_RATE_500 = 2'b01,
    CANMON_RATE_NS = 2'b10
  } canmon_rate_t;
  typedef enum logic [1:0] {
    CANMON_FREQ_NONE = 2'b00,
    CANMON_FREQ_250 = 2'b01,
    CANMON_FREQ_500 = 2'b10,
    CANMON_FREQ_OTHER = 2'b11
  } canmon_freq_t;
endpackage

// ### src/canmon_edge_counter.sv
`timescale 1ns/1ps
`include "canmon_regs.svh"
module canmon_edge_counter #(
  parameter int CNT_W = 16,
  parameter int SP_W = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Monitored line and window tick
  input wire logic can_rx,
  input wire logic win_tick,
  // Window results
  output logic [CNT_W-1:0] win_count,
  output logic [SP_W-1:0] win_spacing
);
  import canmon_pkg::*;
  logic rx_prev_reg;
  logic rise;
  logic [CNT_W-1:0] cnt_reg;
  logic [SP_W-1:0] gap_reg;
  logic [SP_W-1:0] min_reg;
  logic seen_reg;

  // ============================================================
  // Edge detect
  assign rise = can_rx & ~rx_prev_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_prev_reg <= 1'b1;
    end else begin
      rx_prev_reg <= can_rx;
    end
  end

  // ============================================================
  // Edge count, cleared each window
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_reg <= '0;
      win_count <= '0;
    end else if (win_tick) begin
      win_count <= cnt_reg;
      cnt_reg <= rise ? CNT_W'(1) : '0;
    end else if (rise && cnt_reg != '1) begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  // ============================================================
  // Shortest rise-to-rise spacing
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gap_reg <= '0;
      seen_reg <= 1'b0;
      min_reg <= '1;
      win_spacing <= '1;
    end else begin
      if (rise) begin
        gap_reg <= '0;
        seen_reg <= 1'b1;
        if (seen_reg && gap_reg < min_reg) begin
          min_reg <= gap_reg;
        end
      end else if (gap_reg != '1) begin
        gap_reg <= gap_reg + SP_W'(1);
      end
      if (win_tick) begin
        win_spacing <= min_reg;
        min_reg <= '1;
      end
    end
  end
endmodule

// ### bench/cam_checker.sv
`timescale 1ns/1ps
// ============================================================
// Port checker for the activity monitor
module cam_checker #(
  parameter int EVAL_CYCLES = 1800,
  parameter int IDLE_SHORT_WIN = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Monitor and power
  input wire logic can_rx,
  input wire logic pwr_low,
  input wire logic lp_req,
  input wire logic wake_req,
  input wire logic lamp_flash,
  input wire logic send_allowed,
  input wire logic can_active
);
  localparam int GAP_MIN = EVAL_CYCLES - 2;
  localparam int IDLE_MIN = (IDLE_SHORT_WIN - 1) * EVAL_CYCLES;
  logic act_q;
  logic act_seen;
  int act_gap;
  int idle_run;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ============================================================
  // Helper counters
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      act_q <= 1'b0;
      act_seen <= 1'b0;
      act_gap <= 0;
    end else begin
      act_q <= can_active;
      if (can_active != act_q) begin
        act_gap <= 0;
        act_seen <= 1'b1;
      end else if (act_gap < 1000000) begin
        act_gap <= act_gap + 1;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst || can_active) begin
      idle_run <= 0;
    end else if (idle_run < 1000000) begin
      idle_run <= idle_run + 1;
    end
  end
  // ============================================================
  // Assertions
  sequence act_soon_s;
    ##[0:2] can_active;
  endsequence
  err_decode_a: assert property (psel && penable && paddr > 12'h018
    |-> pslverr) else $error("unmapped access without error");
  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  reset_state_a: assert property (disable iff (1'b0) rst |=>
    !lp_req && !wake_req && !can_active && send_allowed)
    else $error("outputs wrong after reset");
  window_pace_a: assert property (
    (can_active != act_q) && act_seen |-> act_gap >= GAP_MIN)
    else $error("activity decision changed within one window");
  lp_idle_a: assert property ($rose(lp_req) |->
    !can_active && idle_run >= IDLE_MIN)
    else $error("low power requested too early");
  lp_sleep_a: assert property (lp_req && pwr_low |=> !lp_req)
    else $error("low power request held in low power");
  wake_cause_a: assert property ($rose(wake_req) |-> act_soon_s)
    else $error("wake without activity");
  wake_sleep_a: assert property ($rose(wake_req) |-> $past(pwr_low))
    else $error("wake outside low power");
  wake_clear_a: assert property (wake_req && !pwr_low |=> !wake_req)
    else $error("wake request held at full power");
  lamp_sleep_a: assert property ($rose(lamp_flash) |-> $past(pwr_low))
    else $error("lamp flash outside low power");
endmodule

bind canmon_top cam_checker #(
  .EVAL_CYCLES(EVAL_CYCLES),
  .IDLE_SHORT_WIN(IDLE_SHORT_WIN)
) u_chk (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .can_rx(can_rx),
  .pwr_low(pwr_low), .lp_req(lp_req), .wake_req(wake_req),
  .lamp_flash(lamp_flash), .send_allowed(send_allowed),
  .can_active(can_active)
);

// ### bench/cam_rx_model.sv
`timescale 1ns/1ps
// ============================================================
// Receive line source: idles high, low pulses of 30 ns
module cam_rx_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic fire,
  input wire logic [7:0] burst_n,
  input wire logic [15:0] period,
  // Line
  output logic can_rx
);
  logic [15:0] ph;
  logic [7:0] left;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ph <= '0;
      left <= '0;
      can_rx <= 1'b1;
    end else if (fire) begin
      ph <= '0;
      left <= burst_n;
      can_rx <= 1'b1;
    end else if (run || left != 8'h00) begin
      can_rx <= (ph >= 16'h0006);
      if (ph >= period - 16'h0001) begin
        ph <= '0;
        if (left != 8'h00) left <= left - 8'h01;
      end else begin
        ph <= ph + 16'h0001;
      end
    end else begin
      can_rx <= 1'b1;
    end
  end
endmodule

// ### bench/can_activity_monitor_tb_top.sv
`timescale 1ns/1ps
`include "canmon_regs.svh"
// ============================================================
// Activity monitor bench
module can_activity_monitor_tb_top;
  import canmon_pkg::*;
  localparam int EVAL = 1800;
  localparam int LIMIT = 95000;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pwr_low = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic pready, pslverr, can_rx, lp_req, wake_req, lamp_flash;
  logic send_allowed, can_active, e, seen;
  logic run = 1'b0, fire = 1'b0;
  logic [7:0] burst_n = 8'h08;
  logic [15:0] period = 16'h000C;
  int err_count = 0, cmp_count = 0, cyc = 0;
  canmon_top #(.EVAL_CYCLES(EVAL), .IDLE_SHORT_WIN(2), .IDLE_LONG_WIN(4))
    uut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .can_rx(can_rx),
    .pwr_low(pwr_low), .lp_req(lp_req), .wake_req(wake_req),
    .lamp_flash(lamp_flash), .send_allowed(send_allowed),
    .can_active(can_active));
  cam_rx_model u_rx (.clk_sys(clk_sys), .rst(rst), .run(run), .fire(fire),
    .burst_n(burst_n), .period(period), .can_rx(can_rx));
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      complete_run();
    end
  end
  // ============================================================
  // Shared tasks
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk32(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic chk1(input logic g, input logic x);
    chk32({31'h0, g}, {31'h0, x});
  endtask
  task automatic xfer(input logic [11:0] a, input logic w,
      input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    run <= 1'b0;
    pwr_low <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return can_active;
      1: return lp_req;
      2: return wake_req;
      default: return lamp_flash;
    endcase
  endfunction
  task automatic wait_lvl(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(s) !== v && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  task automatic watch(input int s, input int lim);
    seen = 1'b0;
    repeat (lim) begin
      @(posedge clk_sys);
      seen = seen | (pick(s) === 1'b1);
    end
  endtask
  // ============================================================
  // Scenarios
  task automatic t_regs();
    logic [11:0] ofs [5] = '{`CANMON_PWR_CTRL_OFS, `CANMON_ACT_OPT_OFS,
      `CANMON_RATE_OPT_OFS, `CANMON_SEARCH_OFS, `CANMON_NS_BIT_OFS};
    logic [31:0] rv [5] = '{32'h0000_0080, 32'h0000_0008, 32'h0000_00FF,
      32'h0000_0000, 32'h0000_03E8};
    for (int i = 0; i < 5; i++) begin
      xfer(ofs[i], 1'b0, 32'h0000_0000);
      chk32(q, rv[i]);
    end
    xfer(12'h020, 1'b0, 32'h0000_0000);
    chk32({q[30:0], e}, 32'h0000_0001);
    xfer(`CANMON_RATE_OPT_OFS, 1'b1, 32'hFFFF_FF3C);
    xfer(`CANMON_RATE_OPT_OFS, 1'b0, 32'h0000_0000);
    chk32(q, 32'h0000_003C);
    xfer(`CANMON_RATE_OPT_OFS, 1'b1, 32'h0000_00FF);
  endtask
  task automatic t_threshold();
    period <= 16'h000C;
    run <= 1'b1;
    wait_lvl(0, 1'b1, 3 * EVAL);
    chk1(can_active, 1'b1);
    run <= 1'b0;
    repeat (5) @(posedge clk_sys);
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (EVAL - 1) @(posedge clk_sys);
    chk1(can_active, 1'b1);
    burst_n <= 8'h07;
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    burst_n <= 8'h08;
    repeat (EVAL + 4) @(posedge clk_sys);
    chk1(can_active, 1'b0);
  endtask
  task automatic t_rate();
    logic [7:0] ctl [7] = '{8'h01, 8'h01, 8'h05, 8'h09, 8'h09, 8'h03,
      8'h00};
    logic [15:0] per [7] = '{16'h0190, 16'h0000, 16'h0320, 16'h0320,
      16'h00C8, 16'h0190, 16'h0190};
    logic [0:6] ok = 7'h37;
    xfer(`CANMON_NS_BIT_OFS, 1'b1, 32'h0000_0064);
    for (int i = 0; i < 7; i++) begin
      xfer(`CANMON_SEARCH_OFS, 1'b1, {24'h00_0000, ctl[i]});
      period <= per[i];
      run <= (per[i] != 16'h0000);
      repeat (2 * EVAL + 10) @(posedge clk_sys);
      chk1(send_allowed, ok[i]);
    end
    run <= 1'b0;
    xfer(`CANMON_SEARCH_OFS, 1'b1, 32'h0000_0000);
  endtask
  task automatic t_sleep_wake();
    do_reset();
    xfer(`CANMON_ACT_OPT_OFS, 1'b1, 32'h0000_0088);
    period <= 16'h000C;
    run <= 1'b1;
    wait_lvl(0, 1'b1, 3 * EVAL);
    run <= 1'b0;
    wait_lvl(0, 1'b0, 2 * EVAL + 10);
    watch(1, EVAL - 10);
    chk1(seen, 1'b0);
    wait_lvl(1, 1'b1, 3 * EVAL);
    chk1(lp_req, 1'b1);
    pwr_low <= 1'b1;
    watch(3, 2 * EVAL + 10);
    chk1(seen, 1'b0);
    run <= 1'b1;
    wait_lvl(2, 1'b1, 2 * EVAL + 10);
    chk1(wake_req, 1'b1);
    pwr_low <= 1'b0;
    run <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk1(wake_req, 1'b0);
  endtask
  task automatic t_wake_perm();
    do_reset();
    xfer(`CANMON_ACT_OPT_OFS, 1'b1, 32'h0000_0090);
    wait_lvl(1, 1'b1, 4 * EVAL);
    chk1(lp_req, 1'b1);
    pwr_low <= 1'b1;
    watch(3, 2 * EVAL + 10);
    chk1(seen, 1'b1);
    run <= 1'b1;
    watch(2, 3 * EVAL);
    chk1(seen, 1'b0);
    pwr_low <= 1'b0;
    run <= 1'b0;
  endtask
  task automatic t_no_entry();
    logic [31:0] pc [2] = '{32'h0000_0000, 32'h0000_0080};
    logic [31:0] sc [2] = '{32'h0000_0000, 32'h0000_0010};
    for (int i = 0; i < 2; i++) begin
      do_reset();
      xfer(`CANMON_ACT_OPT_OFS, 1'b1, 32'h0000_0088);
      xfer(`CANMON_PWR_CTRL_OFS, 1'b1, pc[i]);
      xfer(`CANMON_SEARCH_OFS, 1'b1, sc[i]);
      watch(1, 4 * EVAL);
      chk1(seen, 1'b0);
    end
  endtask
  // ============================================================
  // Main sequence
  initial begin
    do_reset();
    t_regs();
    t_threshold();
    t_rate();
    t_sleep_wake();
    t_wake_perm();
    t_no_entry();
    complete_run();
  end
endmodule
